// File: inc/lafe_if.sv
// lafe_if: pins between the front end and the transceiver core
// assumes: the controller end drives all configuration and serial pins
`timescale 1ns/1ps
interface lafe_if;
  import lafe_pkg::*;
  logic [GAIN_W-1:0] rx_gain_code;
  logic [MODE_W-1:0] rate_mode;
  logic              rx_filter_bypass;
  logic              power_mode_n;
  logic              conv_buffer_bypass;
  logic              tx_atten_sel;
  logic              line_driver_bypass;
  logic              tx_filter_bypass;
  logic              loopback;
  logic              rx_sample_clk;
  logic [RX_W-1:0]   rx_sample_bus;
  logic              tx_ser_clk;
  logic              tx_ser_data;
  logic              tx_sync;
  logic              trec_ser_clk;
  logic              trec_ser_data;
  logic              trec_word_strobe;

  modport dev (
    input  rx_gain_code, rate_mode, rx_filter_bypass, power_mode_n, conv_buffer_bypass,
    input  tx_atten_sel, line_driver_bypass, tx_filter_bypass, loopback,
    input  rx_sample_clk, tx_ser_clk, tx_ser_data, tx_sync,
    input  trec_ser_clk, trec_ser_data, trec_word_strobe,
    output rx_sample_bus
  );
  modport ctl (
    output rx_gain_code, rate_mode, rx_filter_bypass, power_mode_n, conv_buffer_bypass,
    output tx_atten_sel, line_driver_bypass, tx_filter_bypass, loopback,
    output tx_ser_clk, tx_ser_data, tx_sync,
    output trec_ser_clk, trec_ser_data, trec_word_strobe,
    input  rx_sample_clk, rx_sample_bus
  );
endinterface

// File: inc/lafe_pkg.sv
// lafe_pkg: constants and types shared by both ends of the line front end link
// assumes: included before the interface and both end modules
package lafe_pkg;
  localparam int RX_W          = 12;
  localparam int TX_WORD_W     = 16;
  localparam int TX_DAC_W      = 12;
  localparam int TR_DAC_W      = 7;
  localparam int RX_LATENCY    = 3;
  localparam int SYS_PERIOD_NS = 8;
  // serial clock driven by the controller: sys clock divided by 2*half count
  localparam int SER_HALF_CNT  = 3;
  localparam int SER_DIV_W     = 2;
  // fastest receive clock accepted by the converter
  localparam int RX_CLK_MAX_KHZ = 2320;
  localparam int GAIN_W        = 3;
  localparam int MODE_W        = 2;

  typedef enum logic [1:0] {
    LAFE_MODE_HALF   = 2'h0,
    LAFE_MODE_RSVD   = 2'h1,
    LAFE_MODE_SINGLE = 2'h2,
    LAFE_MODE_DOUBLE = 2'h3
  } lafe_mode_t;

  // gain in dB, signed
  typedef logic signed [4:0] lafe_gain_db_t;

  localparam logic [TX_DAC_W-1:0] TX_DAC_RST = 12'h800;
  localparam logic [TR_DAC_W-1:0] TR_DAC_RST = 7'h40;

  function automatic lafe_gain_db_t lafe_gain_db(input logic [GAIN_W-1:0] code);
    unique case (code)
      3'h0:    lafe_gain_db = -5'sd6;
      3'h1:    lafe_gain_db = -5'sd3;
      3'h2:    lafe_gain_db = 5'sd0;
      3'h3:    lafe_gain_db = 5'sd3;
      3'h4:    lafe_gain_db = 5'sd6;
      default: lafe_gain_db = 5'sd9;
    endcase
  endfunction
endpackage

// File: logic/lafe_ctl.sv
// lafe_ctl: transceiver core end: drives config pins, serial words, captures rx
// assumes: SYS_CLK 125 MHz; rx_sample_clk arrives from outside, unrelated to SYS_CLK
`timescale 1ns/1ps

module lafe_ctl (
  // clock and reset
  input  wire logic                            SYS_CLK,
  input  wire logic                            ARST_N,
  // link
  lafe_if.ctl                                  link,
  // configuration levels
  input  wire logic [lafe_pkg::GAIN_W-1:0]     CFG_GAIN,
  input  wire logic [lafe_pkg::MODE_W-1:0]     CFG_MODE,
  input  wire logic [6:0]                      CFG_BYPASS,
  // transmit word request
  input  wire logic                            TX_REQ,
  input  wire logic [lafe_pkg::TX_WORD_W-1:0]  TX_WORD,
  output logic                                 TX_BUSY,
  // timing recovery word request
  input  wire logic                            TR_REQ,
  input  wire logic [lafe_pkg::TX_WORD_W-1:0]  TR_WORD,
  output logic                                 TR_BUSY,
  // received samples
  output logic [lafe_pkg::RX_W-1:0]            RX_DATA
);
  import lafe_pkg::*;

  // config is latched only while idle, keeping the pins static during words
  logic [15:0] cfg_ff;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_ff <= 16'h0140;
    end else if (!TX_BUSY && !TR_BUSY && CFG_MODE != LAFE_MODE_RSVD) begin
      cfg_ff <= {CFG_BYPASS, CFG_MODE, CFG_GAIN, 4'h0};
    end
  end
  assign link.rx_gain_code       = cfg_ff[6:4];
  assign link.rate_mode          = cfg_ff[8:7];
  assign link.rx_filter_bypass   = cfg_ff[9];
  assign link.power_mode_n       = cfg_ff[10];
  assign link.conv_buffer_bypass = cfg_ff[11];
  assign link.tx_atten_sel       = cfg_ff[12];
  assign link.line_driver_bypass = cfg_ff[13];
  assign link.tx_filter_bypass   = cfg_ff[14];
  assign link.loopback           = cfg_ff[15];

  // serial clock divider
  logic [SER_DIV_W-1:0] div_ff;
  logic                 sclk_ff;
  logic                 fall;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_ff  <= '0;
      sclk_ff <= 1'b0;
    end else if (div_ff == SER_DIV_W'(SER_HALF_CNT - 1)) begin
      div_ff  <= '0;
      sclk_ff <= ~sclk_ff;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end
  assign fall = (div_ff == SER_DIV_W'(SER_HALF_CNT - 1)) && sclk_ff;
  assign link.tx_ser_clk   = sclk_ff;
  assign link.trec_ser_clk = sclk_ff;

  // transmit: data changes on falling edges; sync drops at the fall after bit 16
  logic [TX_WORD_W-1:0] tx_sh_ff;
  logic [4:0]           tx_cnt_ff;
  logic                 tx_sync_ff;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_sh_ff   <= '0;
      tx_cnt_ff  <= '0;
      tx_sync_ff <= 1'b0;
    end else if (!tx_sync_ff) begin
      if (TX_REQ && fall) begin
        tx_sh_ff   <= TX_WORD;
        tx_cnt_ff  <= 5'h10;
        tx_sync_ff <= 1'b1;
      end
    end else if (fall) begin
      tx_sh_ff <= {tx_sh_ff[TX_WORD_W-2:0], 1'b0};
      if (tx_cnt_ff == 5'h01) begin
        tx_sync_ff <= 1'b0;
      end
      tx_cnt_ff <= tx_cnt_ff - 5'h01;
    end
  end
  assign link.tx_ser_data = tx_sh_ff[TX_WORD_W-1];
  assign link.tx_sync     = tx_sync_ff;
  assign TX_BUSY          = tx_sync_ff;

  // timing recovery: frame held one bit, word shifts 16 bits
  logic [TX_WORD_W-1:0] tr_sh_ff;
  logic [4:0]           tr_cnt_ff;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tr_sh_ff  <= '0;
      tr_cnt_ff <= '0;
    end else if (tr_cnt_ff == 5'h00) begin
      if (TR_REQ && fall) begin
        tr_sh_ff  <= TR_WORD;
        tr_cnt_ff <= 5'h10;
      end
    end else if (fall) begin
      tr_sh_ff  <= {tr_sh_ff[TX_WORD_W-2:0], 1'b0};
      tr_cnt_ff <= tr_cnt_ff - 5'h01;
    end
  end
  // frame covers only the first bit, well before the last one
  assign link.trec_ser_data    = tr_sh_ff[TX_WORD_W-1];
  assign link.trec_word_strobe = (tr_cnt_ff == 5'h10);
  assign TR_BUSY               = (tr_cnt_ff != 5'h00);

  // receive capture in the link domain on the falling edge, then word handshake
  logic [RX_W-1:0] rx_cap_ff;
  // starts known: the receive clock has no reset, and an unknown toggle never moves
  logic            rx_tog_ff = 1'b0;
  always_ff @(negedge link.rx_sample_clk) begin
    rx_cap_ff <= link.rx_sample_bus;
    rx_tog_ff <= ~rx_tog_ff;
  end
  logic [2:0]      tog_sync_ff;
  logic [RX_W-1:0] rx_data_ff;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tog_sync_ff <= '0;
      rx_data_ff  <= '0;
    end else begin
      tog_sync_ff <= {tog_sync_ff[1:0], rx_tog_ff};
      // capture is stable for a full rx period, far longer than the sync delay
      if (tog_sync_ff[2] != tog_sync_ff[1]) begin
        rx_data_ff <= rx_cap_ff;
      end
    end
  end
  assign RX_DATA = rx_data_ff;
endmodule // lafe_ctl

// File: logic/lafe_dev.sv
// lafe_dev: digital side of the front end: config decode, rx pipeline, serial dac loads
// assumes: the serial clocks come from the controller, rx_sample_clk from outside both ends; no reset pin
`timescale 1ns/1ps

// Behaviour
// - gain code maps -6..9 dB, top codes 9
// - mode selects clock and filter corners
// - high bypasses receive anti-alias filter
// - low power mode pin selects low power
// - high bypasses converter input buffer
// - high gives 6 dB transmit attenuation
// - high bypasses line driver
// - high bypasses transmit low-pass filter
// - high loops transmit back into receive
// - receive input sampled on rising edge
// - receive data valid on falling edge
// - sample appears three clocks later
// - tx sync held one clock minimum
// - tx sync drops after last bit
// - 16-bit tx word, first 12 bits
// - frame pulse held one clock minimum
// - frame pulse drops before last bit
// - 16-bit trec word, first 7 bits
// - receive result in two's complement
// - receive clock at most 2320 kHz; tb drives a 48 ns period, about 20833 kHz
module lafe_dev (
  // link
  lafe_if.dev                                   link,
  // analog side stand-ins
  input  wire logic signed [lafe_pkg::RX_W-1:0] RX_ANALOG_CODE,
  // decoded analog controls
  output lafe_pkg::lafe_gain_db_t               RX_GAIN_DB,
  output lafe_pkg::lafe_mode_t                  RATE_MODE,
  output logic                                  RATE_MODE_ILLEGAL,
  output logic                                  RX_FILTER_IN,
  output logic                                  LOW_POWER,
  output logic                                  CONV_BUFFER_IN,
  output logic                                  TX_ATTEN_6DB,
  output logic                                  LINE_DRIVER_IN,
  output logic                                  TX_FILTER_IN,
  output logic                                  ANALOG_LOOPBACK,
  // converter codes
  output logic [lafe_pkg::TX_DAC_W-1:0]         TX_DAC_CODE,
  output logic [lafe_pkg::TR_DAC_W-1:0]         TR_DAC_CODE
);
  import lafe_pkg::*;

  // static levels, decoded combinationally; the pins are the only state
  always_comb begin
    RX_GAIN_DB        = lafe_gain_db(link.rx_gain_code);
    RATE_MODE         = lafe_mode_t'(link.rate_mode);
    RATE_MODE_ILLEGAL = (link.rate_mode == LAFE_MODE_RSVD);
    RX_FILTER_IN      = ~link.rx_filter_bypass;
    LOW_POWER         = ~link.power_mode_n;
    CONV_BUFFER_IN    = ~link.conv_buffer_bypass;
    TX_ATTEN_6DB      = link.tx_atten_sel;
    LINE_DRIVER_IN    = ~link.line_driver_bypass;
    TX_FILTER_IN      = ~link.tx_filter_bypass;
    ANALOG_LOOPBACK   = link.loopback;
  end

  // receive pipeline: sample, two stages, then output register on the falling edge
  logic [RX_W-1:0] rx_pipe_ff [RX_LATENCY];
  logic [RX_W-1:0] rx_out_ff;

  // no reference clock here, so the receive clock ceiling is relied on, not checked
  always_ff @(posedge link.rx_sample_clk) begin
    rx_pipe_ff[0] <= RX_ANALOG_CODE;
    for (int i = 1; i < RX_LATENCY; i++) begin
      rx_pipe_ff[i] <= rx_pipe_ff[i-1];
    end
  end

  // launched half a cycle early so it is settled at the third rising edge
  always_ff @(negedge link.rx_sample_clk) begin
    rx_out_ff <= rx_pipe_ff[RX_LATENCY-1];
  end
  assign link.rx_sample_bus = rx_out_ff;

  // transmit word: shift while sync high, load dac on sync fall
  logic [TX_WORD_W-1:0] tx_shift_ff;
  logic                 tx_sync_d_ff;
  logic [TX_DAC_W-1:0]  tx_dac_ff = TX_DAC_RST;

  always_ff @(posedge link.tx_ser_clk) begin
    tx_sync_d_ff <= link.tx_sync;
    if (link.tx_sync) begin
      tx_shift_ff <= {tx_shift_ff[TX_WORD_W-2:0], link.tx_ser_data};
    end
    // sync drops only after the last bit's edge, so the word is complete here
    if (tx_sync_d_ff && !link.tx_sync) begin
      tx_dac_ff <= tx_shift_ff[TX_WORD_W-1 -: TX_DAC_W];
    end
  end
  assign TX_DAC_CODE = tx_dac_ff;

  // timing recovery word: frame falls before the last bit, so count bits after it
  logic [TX_WORD_W-1:0] tr_shift_ff;
  logic [4:0]           tr_cnt_ff = 5'h10;
  logic [TR_DAC_W-1:0]  tr_dac_ff = TR_DAC_RST;

  always_ff @(posedge link.trec_ser_clk) begin
    tr_shift_ff <= {tr_shift_ff[TX_WORD_W-2:0], link.trec_ser_data};
    if (link.trec_word_strobe) begin
      tr_cnt_ff <= 5'h01;
    end else if (tr_cnt_ff < 5'h10) begin
      tr_cnt_ff <= tr_cnt_ff + 5'h01;
    end
    if (!link.trec_word_strobe && tr_cnt_ff == 5'h0F) begin
      // last of 16 bits arrives on this edge
      tr_dac_ff <= tr_shift_ff[TX_WORD_W-2 -: TR_DAC_W];
    end
  end
  assign TR_DAC_CODE = tr_dac_ff;
endmodule // lafe_dev

// File: verif/lafe_chk.sv
// lafe_chk: concurrent checks on the link between controller and front end
// assumes: instantiated in tb beside lafe_if; link clocks are sampled as data
`timescale 1ns/1ps
module lafe_chk
  import lafe_pkg::*;
(
  // clock and reset
  input wire logic              SYS_CLK,
  input wire logic              ARST_N,
  // link
  input wire logic [GAIN_W-1:0] rx_gain_code,
  input wire logic [MODE_W-1:0] rate_mode,
  input wire logic              tx_ser_clk,
  input wire logic              tx_sync,
  input wire logic              trec_ser_clk,
  input wire logic              trec_word_strobe,
  input wire logic              rx_sample_clk,
  input wire logic [RX_W-1:0]   rx_sample_bus
);
  logic       sclk_ff;
  logic       trclk_ff;
  logic       strb_ff;
  logic [4:0] txc_ff;
  logic [4:0] trc_ff;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_ff  <= 1'b0;
      trclk_ff <= 1'b0;
      strb_ff  <= 1'b0;
    end else begin
      sclk_ff  <= tx_ser_clk;
      trclk_ff <= trec_ser_clk;
      strb_ff  <= trec_word_strobe;
    end
  end

  // rising serial clock edges while the sync pulse stands
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) txc_ff <= 5'h00;
    else if (!tx_sync) txc_ff <= 5'h00;
    else if (tx_ser_clk && !sclk_ff) txc_ff <= txc_ff + 5'h01;
  end

  // starts full so the first frame after reset is not flagged
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) trc_ff <= 5'h10;
    else if (trec_word_strobe && !strb_ff) trc_ff <= 5'h00;
    else if (trec_ser_clk && !trclk_ff && trc_ff != 5'h10) trc_ff <= trc_ff + 5'h01;
  end

  // the receive pipeline shows unknowns until its first sample reaches the bus
  logic [2:0] rx_rise_ff = 3'h0;
  always_ff @(posedge rx_sample_clk) begin
    if (rx_rise_ff != 3'h4) rx_rise_ff <= rx_rise_ff + 3'h1;
  end

  sequence s_sync_hold;
    tx_sync [*6];
  endsequence
  sequence s_strobe_bit;
    trec_word_strobe [*6] ##1 !trec_word_strobe;
  endsequence

  a_mode_not_rsvd: assert property (rate_mode != 2'h1)
    else $error("reserved rate mode driven");
  a_cfg_hold_busy: assert property (tx_sync && $past(tx_sync) |-> $stable({rx_gain_code, rate_mode}))
    else $error("configuration changed during transfer");
  a_sync_min_width: assert property ($rose(tx_sync) |-> s_sync_hold)
    else $error("tx sync shorter than one serial clock");
  a_sync_after_lsb: assert property ($fell(tx_sync) |-> txc_ff == 5'h10)
    else $error("tx sync dropped without sixteen bits");
  a_sync_at_fall: assert property ($rose(tx_sync) |-> !tx_ser_clk)
    else $error("tx sync rose while serial clock high");
  a_strobe_one_bit: assert property ($rose(trec_word_strobe) |-> s_strobe_bit)
    else $error("frame strobe not one serial clock wide");
  a_trec_word_len: assert property ($rose(trec_word_strobe) |-> trc_ff == 5'h10)
    else $error("timing word shorter than sixteen bits");
  a_rx_bus_hold: assert property (rx_rise_ff == 3'h4 && rx_sample_clk && $past(rx_sample_clk)
                                  |-> $stable(rx_sample_bus))
    else $error("receive bus moved while receive clock high");
endmodule // lafe_chk

// File: verif/tb.sv
// tb: both ends joined by lafe_if; config, serial words and receive pipeline
// assumes: receive clock made here, unrelated to the system clock
`timescale 1ns/1ps
module tb;
  import lafe_pkg::*;
  logic                 sys_clk, arst_n, rx_clk, tx_req, tr_req, tx_busy, tr_busy, mode_ill;
  logic                 rxf_in, low_pwr, cbuf_in, att6, drv_in, txf_in, lpbk;
  logic [GAIN_W-1:0]    cfg_gain;
  logic [MODE_W-1:0]    cfg_mode;
  logic [6:0]           cfg_bypass, pat;
  logic [15:0]          tx_word, tr_word;
  logic signed [RX_W-1:0] rx_code;
  logic [RX_W-1:0]      rx_data, hist[$];
  lafe_gain_db_t        gain_db;
  lafe_mode_t           mode_o;
  logic [TX_DAC_W-1:0]  tx_dac;
  logic [TR_DAC_W-1:0]  tr_dac;
  logic [4:0]           gtab[8] = '{5'h1A, 5'h1D, 5'h00, 5'h03, 5'h06, 5'h09, 5'h09, 5'h09};
  logic [1:0]           mset[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [1:0]           mexp[4] = '{2'h0, 2'h0, 2'h2, 2'h3};
  logic [15:0]          words[3] = '{16'h7FF5, 16'h800A, 16'h01FF};
  int                   fail_count, comparisons, cycles;

  lafe_if link();
  assign link.rx_sample_clk = rx_clk;

  lafe_dev i_lafe_dev (.link(link), .RX_ANALOG_CODE(rx_code), .RX_GAIN_DB(gain_db),
    .RATE_MODE(mode_o), .RATE_MODE_ILLEGAL(mode_ill), .RX_FILTER_IN(rxf_in), .LOW_POWER(low_pwr),
    .CONV_BUFFER_IN(cbuf_in), .TX_ATTEN_6DB(att6), .LINE_DRIVER_IN(drv_in),
    .TX_FILTER_IN(txf_in), .ANALOG_LOOPBACK(lpbk), .TX_DAC_CODE(tx_dac), .TR_DAC_CODE(tr_dac));
  lafe_ctl i_lafe_ctl (.SYS_CLK(sys_clk), .ARST_N(arst_n), .link(link), .CFG_GAIN(cfg_gain),
    .CFG_MODE(cfg_mode), .CFG_BYPASS(cfg_bypass), .TX_REQ(tx_req), .TX_WORD(tx_word),
    .TX_BUSY(tx_busy), .TR_REQ(tr_req), .TR_WORD(tr_word), .TR_BUSY(tr_busy), .RX_DATA(rx_data));
  lafe_chk i_lafe_chk (.SYS_CLK(sys_clk), .ARST_N(arst_n), .rx_gain_code(link.rx_gain_code),
    .rate_mode(link.rate_mode), .tx_ser_clk(link.tx_ser_clk), .tx_sync(link.tx_sync),
    .trec_ser_clk(link.trec_ser_clk), .trec_word_strobe(link.trec_word_strobe),
    .rx_sample_clk(link.rx_sample_clk), .rx_sample_bus(link.rx_sample_bus));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    rx_clk = 1'b0;
    #3.7;
    forever #24 rx_clk = ~rx_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%0h expected=%0h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // waits are sampled on the falling edge so drives stay on the rising one
  task automatic send(input logic sel, input logic [15:0] w);
    int i;
    @(posedge sys_clk);
    if (sel) begin tr_word <= w; tr_req <= 1'b1; end
    else begin tx_word <= w; tx_req <= 1'b1; end
    for (i = 0; i < 20 && (sel ? tr_busy : tx_busy) !== 1'b1; i++) @(negedge sys_clk);
    check(16'(sel ? tr_busy : tx_busy), 16'h0001);
    @(posedge sys_clk);
    tx_req <= 1'b0;
    tr_req <= 1'b0;
    for (i = 0; i < 300 && (sel ? tr_busy : tx_busy) !== 1'b0; i++) @(negedge sys_clk);
    check(16'(sel ? tr_busy : tx_busy), 16'h0000);
    repeat (12) @(negedge sys_clk);
  endtask

  // pipeline: the bus at rise k carries the code sampled at rise k-3, rx_data one rise later
  always @(posedge rx_clk) begin
    if (hist.size() >= 3) check(16'(link.rx_sample_bus), 16'(hist[hist.size()-3]));
    if (hist.size() >= 4) check(16'(rx_data), 16'(hist[hist.size()-4]));
    hist.push_back(rx_code);
    rx_code <= rx_code + 12'h123;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    {arst_n, tx_req, tr_req, cfg_gain, cfg_mode} = '0;
    {tx_word, tr_word} = '0;
    cfg_bypass = 7'h02;
    rx_code = 12'h805;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    check(16'(tx_dac), 16'h0800);
    check(16'(tr_dac), 16'h0040);
    for (int g = 0; g < 8; g++) begin
      @(posedge sys_clk) cfg_gain <= 3'(g);
      repeat (4) @(negedge sys_clk);
      check(16'($unsigned(gain_db)), 16'(gtab[g]));
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk) cfg_mode <= mset[m];
      repeat (4) @(negedge sys_clk);
      check(16'({mode_ill, mode_o}), 16'(mexp[m]));
    end
    for (int b = 0; b < 9; b++) begin
      pat = (b < 7) ? (7'h01 << b) : ((b == 7) ? 7'h00 : 7'h7F);
      @(posedge sys_clk) cfg_bypass <= pat;
      repeat (4) @(negedge sys_clk);
      check(16'({lpbk, !txf_in, !drv_in, att6, !cbuf_in, !low_pwr, !rxf_in}), 16'(pat));
    end
    @(posedge sys_clk) cfg_bypass <= 7'h02;
    foreach (words[k]) begin
      send(1'b0, words[k]);
      check(16'(tx_dac), 16'(words[k][15:4]));
      send(1'b1, ~words[k]);
      check(16'(tr_dac), 16'(tr_word[15:9]));
    end
    test_done();
  end
endmodule // tb
